// ===== bench/cpu_hold_model.sv
/*
  CPU side of the HOLD handshake: acknowledges once its bus cycle ends.
  Assumes hold is a registered output on the same clock.
*/
`timescale 1ns/1ps
module cpu_hold_model (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic slow_answer,
  input  wire logic hold,
  output logic      hold_acknowledge
);
  logic [3:0] busy_ff;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_ff          <= 4'h0;
      hold_acknowledge <= 1'b0;
    end
    else if (!hold)
    begin
      busy_ff          <= slow_answer ? 4'h9 : 4'h2;
      hold_acknowledge <= 1'b0;
    end
    else if (busy_ff != 4'h0)
      busy_ff <= busy_ff - 4'h1;
    else
      hold_acknowledge <= 1'b1;
  end
endmodule : cpu_hold_model

// ===== bench/refresh_and_hold_arbiter_properties.sv
/*
  Concurrent checks on the ports of the refresh and hold arbiter.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module refresh_and_hold_arbiter_checker
  import refresh_arbiter_pkg::*;
(
  input wire logic                                clk_sys,
  input wire logic                                rst_b,
  input wire logic                                hidden_refresh_en,
  input wire logic                                hold,
  input wire logic                                hold_acknowledge,
  input wire logic                                dreq,
  input wire logic                                dack,
  input wire logic                                cpu_dram_gnt,
  input wire logic                                cpu_dram_wait,
  input wire logic                                cpu_at_gnt,
  input wire refresh_arbiter_pkg::at_refresh_bus_t at_bus,
  input wire refresh_arbiter_pkg::dram_strobe_t    dram_strobe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence cas_leads;
    !dram_strobe.cas_n[0] && !$past(dram_strobe.cas_n[0]);
  endsequence

  sequence ras_held;
    !dram_strobe.ras_n[0] [*8];
  endsequence

  sequence setup_then_read;
    ##[4:12] !at_bus.memr_n;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  grant_needs_hold_a: assert property (dack |-> hold)
    else $error("dack high without hold");
  grant_after_ack_a: assert property ($rose(dack) |-> $past(hold_acknowledge, 2))
    else $error("dack rose before hold acknowledge");
  normal_refresh_hold_a: assert property (
    $fell(at_bus.rfsh_n) && !hidden_refresh_en |-> hold && $past(hold_acknowledge, 2))
    else $error("normal refresh started without bus ownership");
  no_preempt_a: assert property (dack |-> at_bus.rfsh_n)
    else $error("refresh ran while bus granted");
  grant_persists_a: assert property (
    dack && dreq && $past(dreq) && $past(dreq, 2) |=> dack)
    else $error("grant withdrawn while request held");
  refresh_cmd_a: assert property (
    !at_bus.memr_n |-> !at_bus.rfsh_n && at_bus.addr_oe && at_bus.cmd_oe)
    else $error("read strobe outside refresh cycle");
  refresh_span_a: assert property (
    $fell(at_bus.rfsh_n) |-> !at_bus.rfsh_n throughout setup_then_read)
    else $error("refresh command missing or cut short");
  cbr_order_a: assert property ($fell(dram_strobe.ras_n[0]) |-> cas_leads ##0 ras_held)
    else $error("row strobe not preceded by column strobe");
  dram_gnt_idle_a: assert property (
    cpu_dram_gnt |-> (&dram_strobe.ras_n) && !cpu_dram_wait)
    else $error("dram granted during refresh");
  at_gnt_free_a: assert property (cpu_at_gnt |-> at_bus.rfsh_n && !hold && !dack)
    else $error("bus granted to cpu while busy");
endmodule : refresh_and_hold_arbiter_checker

// ===== bench/tb_refresh_and_hold_arbiter.sv
/*
  Directed testbench for the refresh and hold arbiter with a CPU model.
  Assumes the package timing constants and the hand-over latencies.
*/
`timescale 1ns/1ps
`define CHECK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
`define WAIT_UNTIL(c, n) begin wcount = 0; do begin @(posedge clk_sys); #1; wcount++; end \
  while (!(c) && wcount < (n)); if (!(c)) begin errors++; finish_test(); end end
module tb_refresh_and_hold_arbiter;
  import refresh_arbiter_pkg::*;
  logic            clk_sys, rst_b, hidden_refresh_en, slow_refresh_en;
  logic            hold, hold_acknowledge, dreq, dack, master_n, isa_rfsh_n;
  logic            cpu_dram_req, cpu_dram_gnt, cpu_dram_wait;
  logic            cpu_at_req, cpu_at_gnt, cpu_at_wait, slow_answer, rfsh_q;
  at_refresh_bus_t at_bus;
  dram_strobe_t    dram_strobe;
  int              errors, cmp_count, wcount, gap, since_fall;

  refresh_and_hold_arbiter u_refresh_and_hold_arbiter (.clk_sys(clk_sys), .rst_b(rst_b),
    .hidden_refresh_en(hidden_refresh_en), .slow_refresh_en(slow_refresh_en), .hold(hold),
    .hold_acknowledge(hold_acknowledge), .dreq(dreq), .dack(dack), .master_n(master_n),
    .isa_rfsh_n(isa_rfsh_n), .cpu_dram_req(cpu_dram_req), .cpu_dram_gnt(cpu_dram_gnt),
    .cpu_dram_wait(cpu_dram_wait), .cpu_at_req(cpu_at_req), .cpu_at_gnt(cpu_at_gnt),
    .cpu_at_wait(cpu_at_wait), .at_bus(at_bus), .dram_strobe(dram_strobe));
  cpu_hold_model u_cpu (.clk_sys(clk_sys), .rst_b(rst_b), .slow_answer(slow_answer),
    .hold(hold), .hold_acknowledge(hold_acknowledge));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Cycles between refresh command starts
  always @(negedge clk_sys)
  begin
    rfsh_q     <= at_bus.rfsh_n;
    since_fall <= (rfsh_q && !at_bus.rfsh_n) ? 1 : since_fall + 1;
    if (rfsh_q && !at_bus.rfsh_n)
      gap <= since_fall;
  end

  task finish_test;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task normal_refresh;
    `WAIT_UNTIL(!at_bus.rfsh_n, 3400)
    `CHECK(hold, 1'b1)
    `CHECK(at_bus.addr_oe, 1'b1)
    `CHECK(at_bus.addr, 8'h00)
    `WAIT_UNTIL(dram_strobe.cas_n !== 4'hf, 4)
    `CHECK(dram_strobe.ras_n, 4'hf)
    `WAIT_UNTIL(dram_strobe.ras_n !== 4'hf, 6)
    `CHECK(dram_strobe.cas_n, 4'h0)
    `WAIT_UNTIL(!hold, 300)
    `WAIT_UNTIL(!at_bus.rfsh_n, 3400)
    `CHECK(at_bus.addr, 8'h01)
    `WAIT_UNTIL(!hold, 300)
    `CHECK(gap, 3180)
  endtask : normal_refresh

  task dma_latched;
    @(posedge clk_sys);
    slow_answer <= 1'b1;
    dreq        <= 1'b1;
    `WAIT_UNTIL(dack, 60)
    `CHECK(hold, 1'b1)
    repeat (3300) @(posedge clk_sys);
    #1;
    `CHECK(at_bus.rfsh_n, 1'b1)
    @(posedge clk_sys);
    dreq <= 1'b0;
    `WAIT_UNTIL(!dack, 20)
    `WAIT_UNTIL(!at_bus.rfsh_n, 10)
    `CHECK(dack, 1'b0)
    `CHECK(hold, 1'b1)
    `WAIT_UNTIL(!hold, 300)
    slow_answer <= 1'b0;
  endtask : dma_latched

  task master_refresh;
    @(posedge clk_sys);
    master_n <= 1'b0;
    dreq     <= 1'b1;
    `WAIT_UNTIL(dack, 60)
    @(posedge clk_sys);
    isa_rfsh_n <= 1'b0;
    dreq       <= 1'b0;
    `WAIT_UNTIL(dram_strobe.cas_n !== 4'hf, 10)
    `CHECK(dram_strobe.ras_n, 4'hf)
    `CHECK(dack, 1'b1)
    @(posedge clk_sys);
    isa_rfsh_n <= 1'b1;
    master_n   <= 1'b1;
    `WAIT_UNTIL(!dack, 20)
    `WAIT_UNTIL(!hold, 100)
  endtask : master_refresh

  task hidden_refresh;
    @(posedge clk_sys);
    hidden_refresh_en <= 1'b1;
    cpu_dram_req      <= 1'b1;
    `WAIT_UNTIL(!at_bus.rfsh_n, 3400)
    `CHECK(hold, 1'b0)
    `CHECK(dram_strobe.cas_n, 4'hf)
    @(posedge clk_sys);
    cpu_at_req   <= 1'b1;
    cpu_dram_req <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHECK({cpu_at_wait, cpu_at_gnt}, 2'b10)
    `WAIT_UNTIL(dram_strobe.cas_n !== 4'hf, 10)
    `CHECK(hold, 1'b0)
    @(posedge clk_sys);
    cpu_dram_req <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHECK({cpu_dram_wait, cpu_dram_gnt}, 2'b10)
    `WAIT_UNTIL(cpu_dram_gnt, 100)
    `WAIT_UNTIL(cpu_at_gnt, 300)
    @(posedge clk_sys);
    cpu_dram_req      <= 1'b0;
    cpu_at_req        <= 1'b0;
    hidden_refresh_en <= 1'b0;
  endtask : hidden_refresh

  task slow_refresh;
    @(posedge clk_sys);
    slow_refresh_en <= 1'b1;
    repeat (3)
    begin
      `WAIT_UNTIL(!at_bus.rfsh_n, 13000)
      `WAIT_UNTIL(at_bus.rfsh_n, 300)
    end
    `CHECK(gap, 12720)
  endtask : slow_refresh

  initial
  begin
    {errors, cmp_count, gap, since_fall} = '0;
    {rst_b, hidden_refresh_en, slow_refresh_en, dreq, cpu_dram_req, cpu_at_req} = '0;
    {master_n, isa_rfsh_n, slow_answer, rfsh_q} = 4'he;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    #1;
    `CHECK({hold, dack, at_bus.rfsh_n, at_bus.memr_n, dram_strobe}, 12'h3ff)
    normal_refresh();
    dma_latched();
    master_refresh();
    hidden_refresh();
    slow_refresh();
    finish_test();
  end
endmodule : tb_refresh_and_hold_arbiter

bind refresh_and_hold_arbiter refresh_and_hold_arbiter_checker u_checker (.clk_sys(clk_sys),
  .rst_b(rst_b), .hidden_refresh_en(hidden_refresh_en), .hold(hold),
  .hold_acknowledge(hold_acknowledge), .dreq(dreq), .dack(dack),
  .cpu_dram_gnt(cpu_dram_gnt), .cpu_dram_wait(cpu_dram_wait), .cpu_at_gnt(cpu_at_gnt),
  .at_bus(at_bus), .dram_strobe(dram_strobe));

// ===== rtl/_unused_placeholder_none.sv
`timescale 1ns/1ps

// ===== rtl/cbr_refresh_sequencer.sv
/*
  CAS-before-RAS refresh sequencer for the local DRAM banks.
  Assumes start is a same-clock request; it is ignored while busy.
*/
`timescale 1ns/1ps
module cbr_refresh_sequencer
  import refresh_arbiter_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rst_sync_b,
  input  wire logic   start,
  output logic        busy,
  output logic        done,
  output refresh_arbiter_pkg::dram_strobe_t strobe
);
  import refresh_arbiter_pkg::*;

  typedef struct packed {
    cbr_state_t   state;
    logic [CNT_W-1:0] cnt;
    logic         done;
    dram_strobe_t strobe;
  } cbr_seq_t;

  cbr_seq_t st_ff;
  cbr_seq_t nxt_st;

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (st_ff.cnt != '0)
      nxt_st.cnt = st_ff.cnt - CNT_W'(1);
    unique case (st_ff.state)
      CBR_IDLE:
      begin
        if (start)
        begin
          nxt_st.state        = CBR_CAS;
          nxt_st.strobe.cas_n = '0;
          nxt_st.cnt          = CBR_CAS_LEAD_CNT - CNT_W'(1);
        end
      end
      CBR_CAS:
      begin
        if (st_ff.cnt == '0)
        begin
          nxt_st.state        = CBR_RAS;
          nxt_st.strobe.ras_n = '0;
          nxt_st.cnt          = CBR_RAS_LOW_CNT - CNT_W'(1);
        end
      end
      CBR_RAS:
      begin
        if (st_ff.cnt == '0)
        begin
          nxt_st.state  = CBR_PRE;
          nxt_st.strobe = '1;
          nxt_st.cnt    = CBR_PRECHARGE_CNT - CNT_W'(1);
        end
      end
      CBR_PRE:
      begin
        if (st_ff.cnt == '0)
        begin
          nxt_st.state = CBR_IDLE;
          nxt_st.done  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      st_ff.state  <= CBR_IDLE;
      st_ff.cnt    <= '0;
      st_ff.done   <= 1'b0;
      st_ff.strobe <= '1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign busy   = (st_ff.state != CBR_IDLE);
  assign done   = st_ff.done;
  assign strobe = st_ff.strobe;

endmodule : cbr_refresh_sequencer

// ===== rtl/refresh_and_hold_arbiter.sv
/*
  Refresh generation and bus ownership arbitration: periodic and bus
  master refresh, CAS-before-RAS local refresh, normal or hidden mode,
  and first-come arbitration of DMA, AT masters and AT refresh over HOLD.
  Assumes hold_acknowledge, dreq, master_n and isa_rfsh_n are pins from
  outside the clock domain; CPU request inputs come from same-clock logic
  and stay high until granted and the cycle ends.
*/
`timescale 1ns/1ps
module refresh_and_hold_arbiter
  import refresh_arbiter_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst_b,
  input  wire logic                         hidden_refresh_en,
  input  wire logic                         slow_refresh_en,
  output logic                              hold,
  input  wire logic                         hold_acknowledge,
  input  wire logic                         dreq,
  output logic                              dack,
  input  wire logic                         master_n,
  input  wire logic                         isa_rfsh_n,
  input  wire logic                         cpu_dram_req,
  output logic                              cpu_dram_gnt,
  output logic                              cpu_dram_wait,
  input  wire logic                         cpu_at_req,
  output logic                              cpu_at_gnt,
  output logic                              cpu_at_wait,
  output refresh_arbiter_pkg::at_refresh_bus_t at_bus,
  output refresh_arbiter_pkg::dram_strobe_t    dram_strobe
);
  import refresh_arbiter_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_sync_b;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  assign rst_sync_b = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             hold_acknowledge_s1;
    logic             hold_acknowledge_s2;
    logic             dreq_s1;
    logic             dreq_s2;
    logic             mstr_s1;
    logic             mstr_s2;
    logic             irf_s1;
    logic             irf_s2;
    logic             irf_prev;
    logic             hidden;
    arb_state_t       state;
    logic             hold_for_dma;
    logic             ref_pend;
    logic             dma_first;
    logic             dram_ref_pend;
    logic             at_cmd_phase;
    logic [CNT_W-1:0] at_cnt;
    logic [REFRESH_ADDR_W-1:0] row_addr;
    logic             hold;
    logic             dack;
    at_refresh_bus_t  at_bus;
  } arb_regs_t;

  arb_regs_t st_ff;
  arb_regs_t nxt_st;

  logic refresh_rate_tick;
  logic cbr_go;
  logic cbr_busy;
  logic cbr_done;
  logic dma_req;
  logic master_rfsh;
  logic start_at;
  logic combined_cbr;
  logic pick_refresh;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  refresh_rate_counter u_rate (
    .clk_sys           (clk_sys),
    .rst_sync_b        (rst_sync_b),
    .slow_refresh_en   (slow_refresh_en),
    .refresh_rate_tick (refresh_rate_tick)
  );

  cbr_refresh_sequencer u_cbr (
    .clk_sys    (clk_sys),
    .rst_sync_b (rst_sync_b),
    .start      (cbr_go),
    .busy       (cbr_busy),
    .done       (cbr_done),
    .strobe     (dram_strobe)
  );

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // DRQ or master cycle in progress
  assign dma_req     = st_ff.dreq_s2 | ~st_ff.mstr_s2;
  assign master_rfsh = st_ff.irf_prev & ~st_ff.irf_s2 & ~st_ff.mstr_s2;
  assign pick_refresh = st_ff.ref_pend & (~dma_req | ~st_ff.dma_first);

  assign cpu_dram_gnt  = cpu_dram_req & ~cbr_busy;
  assign cpu_dram_wait = cpu_dram_req & cbr_busy;
  assign cpu_at_gnt    = cpu_at_req & (st_ff.state == ARB_IDLE) & ~st_ff.hold;
  assign cpu_at_wait   = cpu_at_req & ~cpu_at_gnt;

  assign cbr_go = ~cbr_busy & (combined_cbr | master_rfsh |
                  (st_ff.hidden & st_ff.dram_ref_pend & ~cpu_dram_req));

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st          = st_ff;
    start_at        = 1'b0;
    combined_cbr    = 1'b0;
    nxt_st.hold_acknowledge_s1  = hold_acknowledge;
    nxt_st.hold_acknowledge_s2  = st_ff.hold_acknowledge_s1;
    nxt_st.dreq_s1  = dreq;
    nxt_st.dreq_s2  = st_ff.dreq_s1;
    nxt_st.mstr_s1  = master_n;
    nxt_st.mstr_s2  = st_ff.mstr_s1;
    nxt_st.irf_s1   = isa_rfsh_n;
    nxt_st.irf_s2   = st_ff.irf_s1;
    nxt_st.irf_prev = st_ff.irf_s2;
    nxt_st.dma_first = dma_req & (st_ff.dma_first | ~st_ff.ref_pend);

    unique case (st_ff.state)
      ARB_IDLE:
      begin
        nxt_st.hidden = hidden_refresh_en;
        if (pick_refresh && st_ff.hidden)
        begin
          if (!cpu_at_req)
          begin
            nxt_st.state = ARB_HIDDEN_REFRESH;
            start_at     = 1'b1;
          end
        end
        else if (pick_refresh || dma_req)
        begin
          nxt_st.state        = ARB_HOLD_REQ;
          nxt_st.hold         = 1'b1;
          nxt_st.hold_for_dma = ~pick_refresh;
        end
      end
      ARB_HOLD_REQ:
      begin
        // CPU answers when its cycle ends
        if (st_ff.hold_acknowledge_s2)
        begin
          if (st_ff.hold_for_dma)
          begin
            nxt_st.state = ARB_GRANT;
            nxt_st.dack  = 1'b1;
          end
          else
          begin
            nxt_st.state = ARB_AT_REFRESH;
            start_at     = 1'b1;
            combined_cbr = ~st_ff.hidden;
          end
        end
      end
      ARB_GRANT:
      begin
        if (!dma_req)
        begin
          nxt_st.dack = 1'b0;
          if (st_ff.ref_pend)
          begin
            nxt_st.state = ARB_AT_REFRESH;
            start_at     = 1'b1;
            combined_cbr = ~st_ff.hidden;
          end
          else
          begin
            nxt_st.state = ARB_RELEASE;
            nxt_st.hold  = 1'b0;
          end
        end
      end
      ARB_AT_REFRESH, ARB_HIDDEN_REFRESH:
      begin
        if (st_ff.at_cnt != '0)
        begin
          nxt_st.at_cnt = st_ff.at_cnt - CNT_W'(1);
        end
        else if (!st_ff.at_cmd_phase)
        begin
          nxt_st.at_cmd_phase  = 1'b1;
          nxt_st.at_bus.memr_n = 1'b0;
          nxt_st.at_cnt        = AT_RFSH_CMD_CNT - CNT_W'(1);
        end
        else if (st_ff.at_bus.cmd_oe)
        begin
          nxt_st.at_bus   = '{rfsh_n: 1'b1, memr_n: 1'b1, cmd_oe: 1'b0, addr_oe: 1'b0, addr: st_ff.at_bus.addr};
          nxt_st.row_addr = st_ff.row_addr + REFRESH_ADDR_W'(1);
        end
        else if (st_ff.state == ARB_HIDDEN_REFRESH)
        begin
          nxt_st.state = ARB_IDLE;
        end
        else if (!cbr_busy)
        begin
          if (dma_req)
          begin
            nxt_st.state = ARB_GRANT;
            nxt_st.dack  = 1'b1;
          end
          else
          begin
            nxt_st.state = ARB_RELEASE;
            nxt_st.hold  = 1'b0;
          end
        end
      end
      ARB_RELEASE:
      begin
        if (!st_ff.hold_acknowledge_s2)
          nxt_st.state = ARB_IDLE;
      end
    endcase

    if (start_at)
    begin
      nxt_st.at_bus       = '{rfsh_n: 1'b0, memr_n: 1'b1, cmd_oe: 1'b1, addr_oe: 1'b1, addr: st_ff.row_addr};
      nxt_st.at_cmd_phase = 1'b0;
      nxt_st.at_cnt       = AT_RFSH_SETUP_CNT - CNT_W'(1);
      nxt_st.ref_pend     = 1'b0;
    end
    if (master_rfsh)
      nxt_st.ref_pend = 1'b0;
    if (!cbr_busy && st_ff.hidden && st_ff.dram_ref_pend && !cpu_dram_req && !master_rfsh)
      nxt_st.dram_ref_pend = 1'b0;
    // tick latches a request, set wins
    if (refresh_rate_tick)
    begin
      nxt_st.ref_pend = 1'b1;
      if (st_ff.hidden)
        nxt_st.dram_ref_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      st_ff          <= '0;
      st_ff.hold_acknowledge_s1  <= 1'b0;
      st_ff.mstr_s1  <= 1'b1;
      st_ff.mstr_s2  <= 1'b1;
      st_ff.irf_s1   <= 1'b1;
      st_ff.irf_s2   <= 1'b1;
      st_ff.irf_prev <= 1'b1;
      st_ff.hidden   <= HIDDEN_MODE_RST;
      st_ff.state    <= ARB_IDLE;
      st_ff.row_addr <= ROW_ADDR_RST;
      st_ff.at_bus   <= '{rfsh_n: 1'b1, memr_n: 1'b1, cmd_oe: 1'b0, addr_oe: 1'b0, addr: ROW_ADDR_RST};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // DMA grant held by its DRQ or by a master cycle
  assign hold   = st_ff.hold;
  assign dack   = st_ff.dack;
  assign at_bus = st_ff.at_bus;

endmodule : refresh_and_hold_arbiter

// ===== rtl/refresh_arbiter_pkg.sv
/*
  Constants, carrier structs and state types shared by the refresh and
  hold arbiter and its two helper modules.
  Assumes a single 200 MHz system clock for every module that imports it.
*/
package refresh_arbiter_pkg;

  // ----------------------------------------------------------------
  // Clock and refresh rate
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS      = 5000;
  // 15.9 us request period, in ns
  localparam int REFRESH_PERIOD_NS  = 15900;
  localparam int REFRESH_PERIOD_CYC = (REFRESH_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int RATE_CNT_W         = 12;
  localparam logic [RATE_CNT_W-1:0] REFRESH_RELOAD = RATE_CNT_W'(REFRESH_PERIOD_CYC - 1);
  localparam int SLOW_DIV_W         = 2;
  // Slow refresh keeps one base tick in four
  localparam logic [SLOW_DIV_W-1:0] SLOW_LAST = 2'h3;

  // ----------------------------------------------------------------
  // CAS-before-RAS timing, least times rounded up
  // ----------------------------------------------------------------
  localparam int CNT_W              = 8;
  localparam int CBR_CAS_LEAD_NS    = 10;
  localparam int CBR_RAS_LOW_NS     = 80;
  localparam int CBR_PRECHARGE_NS   = 60;
  localparam logic [CNT_W-1:0] CBR_CAS_LEAD_CNT =
    CNT_W'((CBR_CAS_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] CBR_RAS_LOW_CNT =
    CNT_W'((CBR_RAS_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] CBR_PRECHARGE_CNT =
    CNT_W'((CBR_PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ----------------------------------------------------------------
  // AT bus refresh cycle timing
  // ----------------------------------------------------------------
  localparam int AT_RFSH_SETUP_NS   = 40;
  localparam int AT_RFSH_CMD_NS     = 280;
  localparam logic [CNT_W-1:0] AT_RFSH_SETUP_CNT =
    CNT_W'((AT_RFSH_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] AT_RFSH_CMD_CNT =
    CNT_W'((AT_RFSH_CMD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int   REFRESH_ADDR_W   = 8;
  localparam int   DRAM_BANKS       = 4;
  localparam logic HIDDEN_MODE_RST  = 1'b0;
  localparam logic [REFRESH_ADDR_W-1:0] ROW_ADDR_RST = 8'h00;

  // ----------------------------------------------------------------
  // Carriers and state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      rfsh_n;
    logic                      memr_n;
    logic                      cmd_oe;
    logic                      addr_oe;
    logic [REFRESH_ADDR_W-1:0] addr;
  } at_refresh_bus_t;

  typedef struct packed {
    logic [DRAM_BANKS-1:0] ras_n;
    logic [DRAM_BANKS-1:0] cas_n;
  } dram_strobe_t;

  typedef enum logic [1:0] {
    CBR_IDLE,
    CBR_CAS,
    CBR_RAS,
    CBR_PRE
  } cbr_state_t;

  typedef enum logic [2:0] {
    ARB_IDLE,
    ARB_HOLD_REQ,
    ARB_GRANT,
    ARB_AT_REFRESH,
    ARB_HIDDEN_REFRESH,
    ARB_RELEASE
  } arb_state_t;

endpackage : refresh_arbiter_pkg

// ===== rtl/refresh_rate_counter.sv
/*
  Periodic refresh request generator, a rate generator with an optional
  slow mode that passes one tick in four.
  Assumes clk_sys at 200 MHz and a reset already synchronised to it.
*/
`timescale 1ns/1ps
module refresh_rate_counter
  import refresh_arbiter_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_sync_b,
  input  wire logic slow_refresh_en,
  output logic      refresh_rate_tick
);
  import refresh_arbiter_pkg::*;

  typedef struct packed {
    logic [RATE_CNT_W-1:0] cnt;
    logic [SLOW_DIV_W-1:0] slow_cnt;
    logic                  tick;
  } rate_state_t;

  rate_state_t st_ff;
  rate_state_t nxt_st;

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == '0)
    begin
      nxt_st.cnt = REFRESH_RELOAD;
      if (slow_refresh_en)
      begin
        nxt_st.tick     = (st_ff.slow_cnt == SLOW_LAST);
        nxt_st.slow_cnt = st_ff.slow_cnt + 2'h1;
      end
      else
      begin
        nxt_st.tick     = 1'b1;
        nxt_st.slow_cnt = '0;
      end
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt - RATE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign refresh_rate_tick = st_ff.tick;

endmodule : refresh_rate_counter
